// *** rtl/rar_defs.svh ***
// timing counts, field positions and reset values for the rtc alarm and reset unit
`ifndef RAR_DEFS_SVH
`define RAR_DEFS_SVH

`define RAR_CLK_HZ 25000000
`define RAR_FAIL_HZ 20000
// longest allowed gap between oscillator edges before it is declared missing
`define RAR_FAIL_CYCLES ((`RAR_CLK_HZ + `RAR_FAIL_HZ - 1) / `RAR_FAIL_HZ)
`define RAR_RST_SRC_CLK_RST_EN_BIT 7
`define RAR_RST_SRC_SW_FORCE_BIT 4
`define RAR_OSC_CTL_BIAS_DOUBLE_BIT 5
`define RAR_TIMER_WIDTH 32
`define RAR_RESET_PULSE_CYCLES 4
`define RAR_TIMER_RESET 32'h0000_0000

`endif

// *** rtl/rar_pkg.sv ***
// types shared by the rtc alarm and reset unit
package rar_pkg;

	typedef enum logic [1:0] {
		RAR_MODE_FREE = 2'b00,
		RAR_MODE_AUTO = 2'b01
	} rar_mode_e;

	typedef enum logic [1:0] {
		RAR_ST_IDLE = 2'b00,
		RAR_ST_HOLD = 2'b01,
		RAR_ST_DONE = 2'b11
	} rar_rst_state_e;

	typedef struct packed {
		logic alarm_en;
		logic miss_det_en;
		logic clock_reset_enable;
		logic auto_mode;
		logic osc_bias_double;
		logic agc_en;
	} rar_cfg_s;

	typedef struct packed {
		logic alarm_event;
		logic osc_fail_event;
		logic software_reset_force;
		logic sys_reset;
	} rar_stat_s;

endpackage : rar_pkg

// *** rtl/rar_sync.sv ***
// two flip-flop synchroniser with rising edge detect after the second stage
module rar_sync (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic async_i,
	output logic level_o,
	output logic rise_o
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic s1_nxt;
	logic s2_nxt;
	logic s3_nxt;

	always_comb begin
		s1_nxt = async_i;
		s2_nxt = s1_r;
		s3_nxt = s2_r;
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
		end
	end

	assign level_o = s2_r;
	assign rise_o = s2_r & ~s3_r;
endmodule : rar_sync

// *** rtl/rar_unit.sv ***
// rtc timer, alarm and the reset sources it drives
`include "rar_defs.svh"

// Notes on behaviour
// - system reset may come from oscillator failure or from alarm match.
// - oscillator fail only with missing-clock detector on and clock under 20 kHz.
// - alarm when enabled and timer count equals alarm match value.
// - clock events reset only when clock reset enable bit 7 is one.
// - clock-event reset keeps working in suspend and sleep states.
// - clock and software resets never touch the external reset pin.
// - writing one to software reset force bit 4 forces full reset; the code drops such a write while a reset sequence is already running.
// - software reset force reads one after a software-caused reset.
// - free-running 32-bit timer wraps through zero without disruption.
// - auto-reset mode clears timer to zero after each alarm match.
// - bias doubling bit 5 of oscillator control doubles oscillator bias.
module rar_unit
	import rar_pkg::*;
#(
	parameter int TIMER_WIDTH = `RAR_TIMER_WIDTH,
	parameter int FAIL_CYCLES = `RAR_FAIL_CYCLES,
	parameter int PULSE_CYCLES = `RAR_RESET_PULSE_CYCLES
) (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic lfo_clk_i,
	input wire rar_cfg_s cfg_i,
	input wire logic [TIMER_WIDTH-1:0] alarm_match_value_i,
	input wire logic [7:0] rst_src_wdata_i,
	input wire logic rst_src_we_i,
	input wire logic [7:0] osc_ctl_wdata_i,
	input wire logic osc_ctl_we_i,
	input wire logic low_power_i,
	input wire logic timer_load_i,
	input wire logic [TIMER_WIDTH-1:0] timer_load_value_i,
	output logic [TIMER_WIDTH-1:0] timer_o,
	output logic [7:0] reset_source_register_o,
	output logic [7:0] timer_osc_control_o,
	output logic osc_bias_double_o,
	output logic agc_en_o,
	output rar_stat_s stat_o,
	output logic sys_reset_o
);
	if (TIMER_WIDTH != 32) begin : g_bad_width
		$error("timer width must be 32");
	end
	if (FAIL_CYCLES < 2 || PULSE_CYCLES < 1) begin : g_bad_counts
		$error("bad count parameters");
	end

	localparam int FW = $clog2(FAIL_CYCLES + 1);
	localparam int PW = $clog2(PULSE_CYCLES + 1);

	// ======================================================================
	// oscillator edge capture
	logic lfo_level;
	logic lfo_tick;
	rar_sync u_sync (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.async_i(lfo_clk_i),
		.level_o(lfo_level),
		.rise_o(lfo_tick)
	);

	// ======================================================================
	// timer and alarm
	logic [TIMER_WIDTH-1:0] timer_r;
	logic [TIMER_WIDTH-1:0] timer_nxt;
	logic alarm_r;
	logic alarm_nxt;
	logic match;

	assign match = (timer_r == alarm_match_value_i);

	always_comb begin
		timer_nxt = timer_r;
		alarm_nxt = 1'b0;
		if (timer_load_i) begin
			timer_nxt = timer_load_value_i;
		end else if (lfo_tick) begin
			// compare only on the increment edge so a held match fires once
			alarm_nxt = cfg_i.alarm_en & match;
			if (cfg_i.auto_mode && cfg_i.alarm_en && match)
				timer_nxt = '0;
			else
				timer_nxt = timer_r + 1'b1;
		end
	end

	// ======================================================================
	// missing-clock detector
	logic [FW-1:0] gap_r;
	logic [FW-1:0] gap_nxt;
	logic fail_r;
	logic fail_nxt;

	always_comb begin
		gap_nxt = gap_r;
		fail_nxt = 1'b0;
		if (!cfg_i.miss_det_en || lfo_tick) begin
			gap_nxt = '0;
		end else if (gap_r == FW'(FAIL_CYCLES)) begin
			// one event per failure, then wait for the clock to return
			gap_nxt = gap_r;
		end else begin
			gap_nxt = gap_r + 1'b1;
			fail_nxt = (gap_r == FW'(FAIL_CYCLES - 1));
		end
	end

	// ======================================================================
	// reset sources
	logic clk_rst_en_r;
	logic clk_rst_en_nxt;
	logic sw_flag_r;
	logic sw_flag_nxt;
	logic [PW-1:0] pulse_r;
	logic [PW-1:0] pulse_nxt;
	logic sw_cause_r;
	logic sw_cause_nxt;
	logic [7:0] osc_ctl_r;
	logic [7:0] osc_ctl_nxt;
	rar_rst_state_e st_r;
	rar_rst_state_e st_nxt;
	logic clk_req;
	logic sw_req;

	// low_power_i is deliberately not consulted: the source stays armed in
	// suspend and sleep, since this logic runs on an always-on clock
	assign clk_req = clk_rst_en_r & (alarm_r | fail_r);
	assign sw_req = rst_src_we_i & rst_src_wdata_i[`RAR_RST_SRC_SW_FORCE_BIT];

	always_comb begin
		clk_rst_en_nxt = clk_rst_en_r;
		sw_flag_nxt = sw_flag_r;
		sw_cause_nxt = sw_cause_r;
		pulse_nxt = pulse_r;
		st_nxt = st_r;
		osc_ctl_nxt = osc_ctl_r;
		if (osc_ctl_we_i)
			osc_ctl_nxt = osc_ctl_wdata_i;
		if (rst_src_we_i)
			clk_rst_en_nxt = rst_src_wdata_i[`RAR_RST_SRC_CLK_RST_EN_BIT];
		case (st_r)
			RAR_ST_IDLE: begin
				if (sw_req || clk_req) begin
					st_nxt = RAR_ST_HOLD;
					pulse_nxt = PW'(PULSE_CYCLES);
					sw_cause_nxt = sw_req;
				end
			end
			RAR_ST_HOLD: begin
				pulse_nxt = pulse_r - 1'b1;
				if (pulse_r == PW'(1))
					st_nxt = RAR_ST_DONE;
			end
			RAR_ST_DONE: begin
				// the flag survives the reset and names its cause
				sw_flag_nxt = sw_cause_r;
				st_nxt = RAR_ST_IDLE;
			end
			default: st_nxt = RAR_ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			timer_r <= `RAR_TIMER_RESET;
			alarm_r <= 1'b0;
			gap_r <= '0;
			fail_r <= 1'b0;
			clk_rst_en_r <= 1'b0;
			sw_flag_r <= 1'b0;
			sw_cause_r <= 1'b0;
			pulse_r <= '0;
			osc_ctl_r <= 8'h00;
			st_r <= RAR_ST_IDLE;
		end else begin
			timer_r <= timer_nxt;
			alarm_r <= alarm_nxt;
			gap_r <= gap_nxt;
			fail_r <= fail_nxt;
			clk_rst_en_r <= clk_rst_en_nxt;
			sw_flag_r <= sw_flag_nxt;
			sw_cause_r <= sw_cause_nxt;
			pulse_r <= pulse_nxt;
			osc_ctl_r <= osc_ctl_nxt;
			st_r <= st_nxt;
		end
	end

	// ======================================================================
	// outputs; the reset request is internal and has no path to the pin
	assign sys_reset_o = (st_r == RAR_ST_HOLD);
	assign timer_o = timer_r;
	always_comb begin
		reset_source_register_o = 8'h00;
		reset_source_register_o[`RAR_RST_SRC_CLK_RST_EN_BIT] = clk_rst_en_r;
		reset_source_register_o[`RAR_RST_SRC_SW_FORCE_BIT] = sw_flag_r;
	end
	assign timer_osc_control_o = osc_ctl_r;
	assign osc_bias_double_o = osc_ctl_r[`RAR_OSC_CTL_BIAS_DOUBLE_BIT] | cfg_i.osc_bias_double;
	assign agc_en_o = cfg_i.agc_en;
	assign stat_o.alarm_event = alarm_r;
	assign stat_o.osc_fail_event = fail_r;
	assign stat_o.software_reset_force = sw_flag_r;
	assign stat_o.sys_reset = sys_reset_o;

	logic unused_ok;
	// the enable lives in the reset source register, the cfg copy is ignored
	assign unused_ok = lfo_level ^ low_power_i ^ cfg_i.clock_reset_enable;
endmodule : rar_unit

// *** verif/rar_unit_chk.sv ***
// assertions on the ports of the rtc alarm and reset unit
module rar_unit_chk
	import rar_pkg::*;
#(
	parameter int TIMER_WIDTH = 32
) (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire rar_cfg_s cfg_i,
	input wire logic [7:0] rst_src_wdata_i,
	input wire logic rst_src_we_i,
	input wire logic [7:0] osc_ctl_wdata_i,
	input wire logic osc_ctl_we_i,
	input wire logic timer_load_i,
	input wire logic [TIMER_WIDTH-1:0] timer_o,
	input wire logic [7:0] reset_source_register_o,
	input wire logic osc_bias_double_o,
	input wire rar_stat_s stat_o,
	input wire logic sys_reset_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ================================================================
	// checks
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (reset_i);

	a_pulse_len: assert property ($rose(sys_reset_o) |-> sys_reset_o[*4] ##1 !sys_reset_o)
		else $error("reset pulse length wrong");
	a_sw_flag: assert property ((rst_src_we_i && rst_src_wdata_i[4] ##1 $rose(sys_reset_o))
		|-> ##[4:5] reset_source_register_o[4])
		else $error("software reset flag not set");
	a_clk_gate: assert property (!reset_source_register_o[7] && !rst_src_we_i
		|=> !$rose(sys_reset_o))
		else $error("reset while enable clear");
	a_enable_bit: assert property (rst_src_we_i
		|=> reset_source_register_o[7] == $past(rst_src_wdata_i[7]))
		else $error("enable bit not written");
	a_alarm_en: assert property (stat_o.alarm_event |-> $past(cfg_i.alarm_en))
		else $error("alarm while disabled");
	a_alarm_once: assert property (stat_o.alarm_event |=> !stat_o.alarm_event)
		else $error("alarm event too long");
	a_fail_en: assert property (stat_o.osc_fail_event |-> $past(cfg_i.miss_det_en))
		else $error("fail while detector off");
	a_bias_set: assert property (osc_ctl_we_i && osc_ctl_wdata_i[5] |=> osc_bias_double_o)
		else $error("bias double not set");
	a_timer_wrap: assert property ($changed(timer_o) && $past(timer_o) == '1
		&& !$past(timer_load_i) && !cfg_i.auto_mode |-> timer_o == '0)
		else $error("timer did not wrap to zero");
	a_auto_zero: assert property ($rose(stat_o.alarm_event) && cfg_i.auto_mode
		|-> timer_o == '0)
		else $error("timer not cleared on alarm");

	c_alarm: cover property (stat_o.alarm_event);
	c_fail: cover property (stat_o.osc_fail_event);
	c_flag: cover property ($rose(reset_source_register_o[4]));
endmodule : rar_unit_chk

bind rar_unit rar_unit_chk #(.TIMER_WIDTH(TIMER_WIDTH)) u_chk (.mclk_i, .reset_i, .cfg_i,
	.rst_src_wdata_i, .rst_src_we_i, .osc_ctl_wdata_i, .osc_ctl_we_i, .timer_load_i, .timer_o,
	.reset_source_register_o, .osc_bias_double_o, .stat_o, .sys_reset_o);

// *** verif/rar_unit_tb.sv ***
// self-checking bench for the rtc alarm and reset unit
module rar_unit_tb
	import rar_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_i = 1'b0, reset_i = 1'b1, lfo_clk_i = 1'b0, low_power_i = 1'b0;
	logic rst_src_we_i = 1'b0, osc_ctl_we_i = 1'b0, timer_load_i = 1'b0;
	logic osc_bias_double_o, agc_en_o, sys_reset_o;
	logic [7:0] rst_src_wdata_i = 8'h00, osc_ctl_wdata_i = 8'h00;
	logic [7:0] reset_source_register_o, timer_osc_control_o;
	logic [31:0] alarm_match_value_i = 32'h0, timer_load_value_i = 32'h0, timer_o;
	rar_cfg_s cfg_i = '0;
	rar_stat_s stat_o;
	int error_cnt = 0, check_count = 0, acnt = 0, fcnt = 0, rcnt = 0;

	// short miss window keeps the oscillator-fail case quick
	rar_unit #(.FAIL_CYCLES(40)) u_dut (.mclk_i, .reset_i, .lfo_clk_i, .cfg_i,
		.alarm_match_value_i, .rst_src_wdata_i, .rst_src_we_i, .osc_ctl_wdata_i,
		.osc_ctl_we_i, .low_power_i, .timer_load_i, .timer_load_value_i, .timer_o,
		.reset_source_register_o, .timer_osc_control_o, .osc_bias_double_o, .agc_en_o,
		.stat_o, .sys_reset_o);

	always #20 mclk_i = ~mclk_i;

	// counted on the falling edge, where the registered pulses have settled
	always @(negedge mclk_i) begin
		if (stat_o.alarm_event === 1'b1)
			acnt++;
		if (stat_o.osc_fail_event === 1'b1)
			fcnt++;
		if ($rose(sys_reset_o))
			rcnt++;
	end

	// ================================================================
	// access tasks
	task chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk

	// spacing after each write keeps clear of the busy reset sequence
	task wr(input logic r, input logic [7:0] d);
		rst_src_wdata_i = d;
		osc_ctl_wdata_i = d;
		rst_src_we_i = r;
		osc_ctl_we_i = !r;
		@(negedge mclk_i);
		rst_src_we_i = 1'b0;
		osc_ctl_we_i = 1'b0;
		repeat (10) @(negedge mclk_i);
	endtask : wr

	task tick(input int n);
		repeat (n) begin
			lfo_clk_i = 1'b1;
			repeat (4) @(negedge mclk_i);
			lfo_clk_i = 1'b0;
			repeat (4) @(negedge mclk_i);
		end
	endtask : tick

	task load(input logic [31:0] v);
		timer_load_value_i = v;
		timer_load_i = 1'b1;
		@(negedge mclk_i);
		timer_load_i = 1'b0;
	endtask : load

	task close_out;
		if (error_cnt == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out

	initial begin
		repeat (5000) @(posedge mclk_i);
		error_cnt++;
		close_out();
	end

	// ================================================================
	// tests
	initial begin
		repeat (20) @(negedge mclk_i);
		reset_i = 1'b0;
		cfg_i.agc_en = 1'b1;
		wr(1'b1, 8'h80);
		chk(reset_source_register_o, 8'h80);
		chk(agc_en_o, 1'b1);
		// self-oscillation with doubled bias from here, so gain control goes off first
		cfg_i.agc_en = 1'b0;
		wr(1'b0, 8'h20);
		chk(agc_en_o, 1'b0);
		chk(osc_bias_double_o, 1'b1);
		chk(timer_osc_control_o, 8'h20);
		load(32'h5);
		alarm_match_value_i = 32'h7;
		cfg_i.alarm_en = 1'b1;
		tick(2);
		chk(timer_o, 32'h7);
		// the held match is only judged on the next increment
		chk(acnt, 0);
		tick(1);
		repeat (20) @(negedge mclk_i);
		chk(acnt, 1);
		chk(rcnt, 1);
		alarm_match_value_i = alarm_match_value_i + 32'h2;
		tick(2);
		chk(acnt, 2);
		chk(timer_o, 32'ha);
		chk(rcnt, 2);
		cfg_i.auto_mode = 1'b1;
		alarm_match_value_i = 32'h3;
		load(32'h0);
		for (int i = 0; i < 5 && acnt < 3; i++)
			tick(1);
		chk(acnt, 3);
		chk(timer_o, 32'h0);
		chk(rcnt, 3);
		cfg_i.auto_mode = 1'b0;
		cfg_i.alarm_en = 1'b0;
		load(32'hffff_ffff);
		tick(1);
		chk(timer_o, 32'h0);
		repeat (50) @(negedge mclk_i);
		chk(fcnt, 0);
		low_power_i = 1'b1;
		cfg_i.miss_det_en = 1'b1;
		repeat (100) @(negedge mclk_i);
		chk(fcnt, 1);
		chk(rcnt, 4);
		wr(1'b1, 8'h10);
		chk(rcnt, 5);
		chk(reset_source_register_o, 8'h10);
		chk(stat_o.software_reset_force, 1'b1);
		// a second reset in mid-run clears the sticky flag
		reset_i = 1'b1;
		repeat (2) @(negedge mclk_i);
		reset_i = 1'b0;
		@(negedge mclk_i);
		chk(reset_source_register_o, 8'h00);
		close_out();
	end
endmodule : rar_unit_tb
